// >>> sbb_bus_if.sv
/*
 * Bus-side logic of a single-UART serial expansion board.
 * Assumes the host issues one-cycle strobes for write, status read and data
 * read, with bus address bit 0 valid alongside; UART pins are asynchronous.
 */
`timescale 1ns/1ns
`default_nettype none
module sbb_bus_if
	import sbb_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	// Host-side bus cycle
	input wire logic bus_addr0,
	input wire logic bus_write,
	input wire logic status_read_cycle,
	input wire logic bus_data_read,
	input wire logic bus_reset_cycle,
	input wire logic [7:0] bus_wdata,
	output logic [7:0] bus_rdata,
	// Shared open-drain attention line
	output logic bus_attention_n_o,
	output logic bus_attention_n_oe_n,
	// UART side
	output logic uart_sel_n,
	output logic [2:0] uart_reg_select,
	output logic uart_reset,
	output logic uart_wr_stb,
	output logic uart_rd_stb,
	output logic [7:0] uart_wdata,
	input wire logic [7:0] uart_rdata,
	input wire logic rx_char_ready,
	input wire logic tx_buffer_empty,
	output logic line_driver_enable
);
	sbb_state_s st_r;
	sbb_state_s st_nxt;
	sbb_ctl_s ctl;
	logic [1:0] ev_sync;
	logic irq_req;
	logic unused_bus_reset;

	// UART flags come from a foreign chip; synchronise before use
	sbb_sync #(
		.WIDTH(2)
	) u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.async_in({rx_char_ready, tx_buffer_empty}),
		.sync_out(ev_sync)
	);

	assign ctl.sel_n = st_r.ctl_raw[CTL_SEL_N_BIT];
	assign ctl.reg_sel = {st_r.ctl_raw[CTL_RS2_BIT], st_r.ctl_raw[CTL_RS1_BIT],
		st_r.ctl_raw[CTL_RS0_BIT]};
	assign ctl.reset = st_r.ctl_raw[CTL_RESET_BIT];
	assign ctl.drv_en = st_r.ctl_raw[CTL_DRV_EN_BIT];

	assign irq_req = ev_sync[1] | ev_sync[0];

	// Bus-wide reset deliberately ignored so a UART session survives it
	assign unused_bus_reset = bus_reset_cycle;

	always_comb begin
		st_nxt = st_r;
		if (bus_write && bus_addr0 == ADDR_CTRL) begin
			st_nxt.ctl_raw = bus_wdata;
		end
		if (status_read_cycle && bus_addr0 == ADDR_CTRL) begin
			st_nxt.rd_data = 8'h00;
			st_nxt.rd_data[STAT_ABSENT_BIT] = 1'b0;
			st_nxt.rd_data[STAT_SERVICE_BIT] = irq_req;
		end else if (bus_data_read && bus_addr0 == ADDR_DATA) begin
			st_nxt.rd_data = ctl.sel_n ? 8'h00 : uart_rdata;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r.ctl_raw <= CTL_RESET_VAL;
			st_r.rd_data <= 8'h00;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign bus_rdata = st_r.rd_data;
	assign uart_sel_n = ctl.sel_n;
	assign uart_reg_select = ctl.reg_sel;
	assign uart_reset = ctl.reset;
	assign line_driver_enable = ctl.drv_en;
	assign uart_wdata = bus_wdata;
	// Strobes reach the UART only while it is selected
	assign uart_wr_stb = bus_write && bus_addr0 == ADDR_DATA && !ctl.sel_n;
	assign uart_rd_stb = bus_data_read && bus_addr0 == ADDR_DATA && !ctl.sel_n;

	// Pull low only; released line floats high for other boards
	assign bus_attention_n_o = 1'b0;
	assign bus_attention_n_oe_n = !irq_req;
endmodule
`default_nettype wire

// >>> sbb_pkg.sv
/*
 * Shared constants and carriers for the serial board bus interface.
 * Assumes a single 100 MHz clock domain; included by both design files.
 */
package sbb_pkg;
	// Control register bit positions (write-only register at the low address)
	localparam int unsigned CTL_SEL_N_BIT = 5;
	localparam int unsigned CTL_RS0_BIT = 4;
	localparam int unsigned CTL_RESET_BIT = 3;
	localparam int unsigned CTL_RS1_BIT = 2;
	localparam int unsigned CTL_DRV_EN_BIT = 1;
	localparam int unsigned CTL_RS2_BIT = 0;
	localparam logic [7:0] CTL_RESET_VAL = 8'h20;
	// Status nibble bit positions
	localparam int unsigned STAT_ABSENT_BIT = 0;
	localparam int unsigned STAT_SERVICE_BIT = 1;
	// Address bit 0 selects control (0) or data (1)
	localparam logic ADDR_CTRL = 1'b0;
	localparam logic ADDR_DATA = 1'b1;
	localparam int unsigned SYNC_STAGES = 2;

	typedef enum logic [1:0] {
		SBB_CYC_NONE = 2'b00,
		SBB_CYC_WRITE = 2'b01,
		SBB_CYC_STATUS = 2'b10,
		SBB_CYC_DATA_RD = 2'b11
	} sbb_cycle_e;

	typedef struct packed {
		logic sel_n;
		logic [2:0] reg_sel;
		logic reset;
		logic drv_en;
	} sbb_ctl_s;

	typedef struct packed {
		logic [7:0] ctl_raw;
		logic [7:0] rd_data;
	} sbb_state_s;
endpackage

// >>> sbb_sync.sv
/*
 * Two-stage synchroniser for a bundle of levels.
 * Assumes inputs are asynchronous to clk; only stage two is visible.
 */
`timescale 1ns/1ns
`default_nettype none
module sbb_sync
	import sbb_pkg::*;
#(
	parameter int unsigned WIDTH = 2
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} sbb_sync_s;

	sbb_sync_s st_r;
	sbb_sync_s st_nxt;

	initial begin
		if (WIDTH < 1) $error("sbb_sync WIDTH must be at least 1");
	end

	always_comb begin
		st_nxt.meta = async_in;
		st_nxt.stable = st_r.meta;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign sync_out = st_r.stable;
endmodule
`default_nettype wire

// >>> sbb_bus_if_assertions.sv
/* Port checker for sbb_bus_if; bound below. */
`timescale 1ns/1ns
`default_nettype none
module sbb_chk(input wire logic clk, rst_n, bus_addr0, bus_write, status_read_cycle,
	bus_attention_n_oe_n, uart_sel_n, uart_reset, uart_wr_stb, rx_char_ready,
	tx_buffer_empty, uart_rd_stb, line_driver_enable, input wire logic [7:0] bus_wdata, bus_rdata,
	input wire logic [2:0] uart_reg_select);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic [7:0] w_r;
	wire cw = bus_write && !bus_addr0;
	wire oe = bus_attention_n_oe_n;
	always_ff @(posedge clk) w_r <= bus_wdata;
	sel_gate_a: assert property (uart_wr_stb |-> !uart_sel_n) else $error("sel");
	rd_gate_a: assert property (uart_rd_stb |-> !uart_sel_n) else $error("rd sel");
	drv_bit_a: assert property (cw |=> line_driver_enable == w_r[1]) else $error("drv");
	reg_map_a: assert property (cw |=> uart_reg_select == {w_r[0], w_r[2], w_r[4]})
		else $error("map");
	ctl_bits_a: assert property (cw |=> {uart_sel_n, uart_reset} == {w_r[5], w_r[3]})
		else $error("ctl");
	reset_hold_a: assert property (!cw |=> $stable(uart_reset)) else $error("rst");
	rx_flag_a: assert property (rx_char_ready [*3] |-> !oe) else $error("rx");
	tx_flag_a: assert property (tx_buffer_empty [*3] |-> !oe) else $error("tx");
	idle_line_a: assert property ((!rx_char_ready && !tx_buffer_empty) [*3] |-> oe)
		else $error("idle");
	stat_bits_a: assert property (status_read_cycle && !bus_addr0 |=>
		bus_rdata == {6'h00, !$past(oe), 1'b0}) else $error("stat");
endmodule
bind sbb_bus_if sbb_chk u_chk(.*);
`default_nettype wire

// >>> sbb_uart_model.sv
/* UART register model; fed by sbb_bus_if strobes. */
`timescale 1ns/1ns
`default_nettype none
module sbb_uart(input wire logic clk, uart_sel_n, uart_reset, uart_wr_stb,
	input wire logic [2:0] uart_reg_select, input wire logic [7:0] uart_wdata,
	output logic [7:0] uart_rdata);
	logic [7:0] m_r [8];
	logic [7:0] q_r = 8'h00;
	always @(posedge clk) begin
		if (uart_reset) m_r <= '{default: 8'h00};
		else if (uart_wr_stb) m_r[uart_reg_select] <= uart_wdata;
		q_r <= uart_rdata;
	end
	// One store for both directions; real chip maps reads apart
	// Deselected bus flips to the inverse of its previous value every cycle
	assign uart_rdata = uart_sel_n ? ~q_r : m_r[uart_reg_select];
endmodule
`default_nettype wire

// >>> sbb_bus_if_tb_top.sv
/* Bench for sbb_bus_if; sbb_uart sits at the far side. */
`timescale 1ns/1ns
`default_nettype none
module sbb_bus_if_tb_top;
	logic clk = 0, rst_n = 0, bus_addr0 = 0, bus_write = 0, bus_data_read = 0;
	logic status_read_cycle = 0, bus_reset_cycle = 0, rx_char_ready = 0, tx_buffer_empty = 0;
	logic bus_attention_n_o, bus_attention_n_oe_n, uart_sel_n, uart_reset, uart_wr_stb;
	logic uart_rd_stb, line_driver_enable;
	logic [7:0] bus_wdata = 0, bus_rdata, uart_wdata, uart_rdata;
	logic [2:0] uart_reg_select;
	int n_fail = 0, n_tests = 0, c;
	always #5 clk = ~clk;
	sbb_bus_if DUT(.*);
	sbb_uart u_far(.*);
	task automatic chk(input logic [7:0] s, e);
		n_tests++;
		if (s !== e) begin
			n_fail++;
			$display("ERROR %0t: %h not %h", $time, s, e);
		end
	endtask
	task automatic close_out;
		$display("%0d of %0d failed", n_fail, n_tests);
		if (n_fail == 0 && n_tests > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// s is {addr0, write, status, data read}; reads expect d
	task automatic bus(input logic [3:0] s, input logic [7:0] d);
		@(negedge clk) {bus_addr0, bus_write, status_read_cycle, bus_data_read, bus_wdata} = {s, d};
		@(negedge clk) {bus_write, status_read_cycle, bus_data_read} = 3'b000;
		if (!s[2]) chk(bus_rdata, d);
	endtask
	initial begin
		repeat (2000) @(posedge clk);
		n_fail++;
		close_out();
	end
	initial begin
		repeat (8) @(negedge clk);
		rst_n = 1;
		bus(4'b0010, 8'h00);
		bus(4'b1100, 8'h55);
		bus(4'b1001, 8'h00);
		bus(4'b0100, 8'h1a);
		bus_reset_cycle = 1;
		@(negedge clk) bus_reset_cycle = 0;
		chk({2'b00, uart_sel_n, uart_reg_select, uart_reset, line_driver_enable}, 8'h07);
		for (c = 0; c < 8; c++) begin
			bus(4'b0100, {3'b000, c[0], 1'b0, c[1], 1'b1, c[2]});
			chk({5'h00, uart_reg_select}, 8'(c));
			bus(4'b1100, 8'h40 + 8'(c));
			bus(4'b1001, 8'h40 + 8'(c));
		end
		for (c = 1; c < 3; c++) begin
			{rx_char_ready, tx_buffer_empty} = 2'(c);
			repeat (3) @(negedge clk);
			chk({7'h00, bus_attention_n_oe_n}, 8'h00);
			bus(4'b0010, 8'h02);
			{rx_char_ready, tx_buffer_empty} = 2'b00;
			repeat (3) @(negedge clk);
			bus(4'b0010, 8'h00);
		end
		bus(4'b0100, 8'h20);
		chk({6'h00, line_driver_enable, bus_attention_n_o}, 8'h00);
		close_out();
	end
endmodule
`default_nettype wire
